// ==== tb/cmc_bus_model.sv ====
// snooping bus agent model
`timescale 1ns/10ps
module cmc_bus_model (
    input wire clock_i,
    input wire en_i,
    input wire [3:0] rnd_i,
    output reg [3:0] snoop_o
);
initial snoop_o = 4'h0;
// draw taken one falling edge late, so it never races the bench
always @(negedge clock_i) begin
    snoop_o <= {en_i & rnd_i[0], rnd_i[3:1]};
end
endmodule // cmc_bus_model

// ==== tb/cmc_mode_ctrl_props.sv ====
// assertions for cmc_mode_ctrl
`timescale 1ns/10ps
module cmc_mode_ctrl_props (
    input logic clock_i,
    input logic rst_b_i,
    input logic ctrl_wr_i,
    input logic ctrl_priv_i,
    input logic [31:0] ctrl_wdata_i,
    input logic [31:0] ctrl_rdata_o,
    input logic protection_fault_o,
    input logic [15:0] fault_code_o,
    input logic range_types_on_i,
    input logic acc_valid_i,
    input logic acc_rd_i,
    input logic acc_wr_i,
    input logic acc_hit_i,
    input logic acc_uncached_i,
    input logic [1:0] acc_line_state_i,
    input logic pol_allocate_o,
    input logic pol_update_line_o,
    input logic pol_mem_write_o,
    input logic pol_rd_inval_o,
    input logic strict_order_o,
    input logic snoop_valid_i,
    input logic snoop_ack_o,
    input logic [1:0] mode_o
);
reg [1:0] live_q; // follows the design's two-flop release
always @(posedge clock_i or negedge rst_b_i) live_q <= rst_b_i ? {live_q[0], 1'h1} : 2'h0;
wire rm = acc_valid_i & !acc_hit_i & acc_rd_i;
wire w = acc_valid_i & acc_wr_i;
wire mw = !acc_hit_i || acc_line_state_i == 2'h1;
wire so = !range_types_on_i || acc_uncached_i;
default clocking @(posedge clock_i); endclocking
default disable iff (!live_q[1]);
a_bad_write:
    assert property (ctrl_wr_i && (!ctrl_priv_i || ctrl_wdata_i[30:29] == 2'h1)
    |=> protection_fault_o && $stable(ctrl_rdata_o)) else $error("bad write");
a_fault_code:
    assert property (protection_fault_o |-> fault_code_o == 16'h0000) else $error("code");
a_mode_map:
    assert property (mode_o == {1'h0, ctrl_rdata_o[30]}) else $error("mode");
a_nofill_rd:
    assert property (rm && mode_o == 2'h1 |=> !pol_allocate_o) else $error("fill");
a_wmiss_fill:
    assert property (w && !acc_hit_i && !acc_uncached_i && mode_o == 2'h0 |=> pol_allocate_o)
    else $error("no fill");
a_whit_upd:
    assert property (w && acc_hit_i |=> pol_update_line_o) else $error("update");
a_mem_write:
    assert property (w |=> pol_mem_write_o == $past(mw)) else $error("memory write");
a_read_fill:
    assert property (rm && !acc_uncached_i && mode_o == 2'h0 |=> pol_allocate_o)
    else $error("read fill");
a_shared_inval:
    assert property (w && acc_hit_i && acc_line_state_i == 2'h1 && mode_o == 2'h0
    |=> pol_rd_inval_o) else $error("read invalidate");
a_strict_order:
    assert property (acc_valid_i |=> strict_order_o == $past(so)) else $error("ordering");
a_snoop_ack:
    assert property (snoop_valid_i |=> snoop_ack_o) else $error("snoop");
cover property (protection_fault_o);
cover property (rm && mode_o == 2'h1);
cover property (snoop_valid_i && mode_o == 2'h0);
cover property (w && acc_hit_i && acc_line_state_i == 2'h1 && mode_o == 2'h0);
endmodule // cmc_mode_ctrl_props
bind cmc_mode_ctrl cmc_mode_ctrl_props u_props (.*);

// ==== tb/cmc_mode_ctrl_tb.sv ====
// random bench for cmc_mode_ctrl
`timescale 1ns/10ps
module cmc_mode_ctrl_tb;
logic clock_i, rst_b_i, ctrl_wr_i, ctrl_priv_i, range_types_on_i, acc_valid_i, acc_rd_i;
logic acc_wr_i, acc_hit_i, acc_uncached_i, ctrl_done_o, protection_fault_o, pol_valid_o;
logic pol_allocate_o, pol_update_line_o, pol_mem_write_o, pol_rd_inval_o, strict_order_o;
logic snoop_valid_i, snoop_inval_i, snoop_ack_o, snoop_hitm_o, m, bad, fl;
logic [1:0] acc_line_state_i, snoop_line_state_i, pol_new_state_o, snoop_new_state_o, mode_o;
logic [1:0] sx;
logic [3:0] ex, snp_rnd;
wire [3:0] snoop_bus;
logic [31:0] ctrl_wdata_i, ctrl_rdata_o, r, rq;
logic [15:0] fault_code_o;
integer mismatches = 0, compares = 0, i;
cmc_mode_ctrl u_dut (.*);
cmc_bus_model u_bus (.clock_i(clock_i), .en_i(rst_b_i), .rnd_i(snp_rnd), .snoop_o(snoop_bus));
assign {snoop_valid_i, snoop_inval_i, snoop_line_state_i} = snoop_bus;
function automatic [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function automatic [3:0] pe(input m, w, h, u, input [1:0] s);
    pe = {!h & !u & !m, w & (!h | s == 2'h1), w & h, w & h & s == 2'h1 & !m};
endfunction
// next line state: read fill gives exclusive, write hit on exclusive (or on shared in normal mode) gives modified
function automatic [1:0] ns(input m, w, h, u, input [1:0] s);
    ns = !w & !h & !u & !m ? 2'h2 : w & h & (s == 2'h2 | s == 2'h1 & !m) ? 2'h3 : s;
endfunction
task automatic chk(input [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
endtask
task automatic finish_test;
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
end
initial begin
    {rst_b_i, ctrl_wr_i, ctrl_priv_i, range_types_on_i, acc_valid_i} = 5'h00;
    {acc_rd_i, acc_wr_i, acc_hit_i, acc_uncached_i, fl} = 5'h00;
    {ctrl_wdata_i, acc_line_state_i} = 34'h0;
    snp_rnd = 4'h0;
    r = 32'h7877;
    rq = 32'h40000000;
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'h1;
    repeat (3) @(negedge clock_i);
    chk(ctrl_rdata_o, rq);
    chk(mode_o, 2'h1);
    for (i = 0; i < 3000; i = i + 1) begin
        r = nxt(r);
        m = rq[30];
        ctrl_wr_i = r[2:0] == 3'h0 || i < 3;
        ctrl_priv_i = r[3] | r[4] | i < 2;
        // both flags cleared for speed, then the refused pair right behind it
        ctrl_wdata_i = i == 0 ? 32'h00000000 : i == 1 ? 32'h20000000 : r;
        bad = ctrl_wr_i & (!ctrl_priv_i | ctrl_wdata_i[30:29] == 2'h1);
        // a just-set disable flag is followed by a flushed cache: no hit
        {acc_valid_i, acc_wr_i, acc_hit_i, range_types_on_i} = r[8:5] & {2'h3, !fl, 1'h1};
        acc_rd_i = !acc_wr_i;
        acc_uncached_i = r[9] & r[10];
        acc_line_state_i = !acc_hit_i ? 2'h0 : r[11] ? 2'h1 : r[13:12] | 2'h2;
        snp_rnd <= r[17:14];
        @(negedge clock_i);
        chk(protection_fault_o, bad);
        if (bad) chk(fault_code_o, 16'h0000);
        chk(ctrl_done_o, ctrl_wr_i);
        fl = ctrl_wr_i & !bad & !rq[30] & ctrl_wdata_i[30];
        if (ctrl_wr_i & !bad) rq = ctrl_wdata_i;
        chk(ctrl_rdata_o, rq);
        chk(mode_o, {1'h0, rq[30]});
        ex = pe(m, acc_wr_i, acc_hit_i, acc_uncached_i, acc_line_state_i) & {4{acc_valid_i}};
        sx = !acc_valid_i ? acc_line_state_i
            : ns(m, acc_wr_i, acc_hit_i, acc_uncached_i, acc_line_state_i);
        chk({pol_valid_o, pol_allocate_o}, {acc_valid_i, ex[3]});
        chk({pol_mem_write_o, pol_update_line_o, pol_rd_inval_o}, ex[2:0]);
        chk(pol_new_state_o, sx);
        chk(strict_order_o, !range_types_on_i | acc_uncached_i);
        chk(snoop_ack_o, snoop_valid_i);
        chk(snoop_hitm_o, snoop_valid_i & snoop_line_state_i == 2'h3);
        if (snoop_valid_i) chk({snoop_ack_o, snoop_new_state_o},
            {1'h1, snoop_inval_i | snoop_line_state_i == 2'h0 ? 2'h0 : 2'h1});
    end
    // reset in mid-run must bring back the no-fill state
    ctrl_wr_i = 1'h0;
    acc_valid_i = 1'h0;
    snp_rnd <= 4'h0;
    rst_b_i = 1'h0;
    @(negedge clock_i);
    chk(ctrl_rdata_o, 32'h40000000);
    chk({mode_o, pol_valid_o, protection_fault_o, snoop_ack_o}, 5'h08);
    rst_b_i = 1'h1;
    repeat (3) @(negedge clock_i);
    chk(mode_o, 2'h1);
    finish_test;
end
endmodule // cmc_mode_ctrl_tb

// ==== verilog/cmc_map.vh ====
// constants for the cache mode control block
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
`define CMC_CTRL_W 32
`define CMC_CD_BIT 30
`define CMC_NW_BIT 29
`define CMC_MODE_W 2
`define CMC_MODE_NORMAL 2'h0
`define CMC_MODE_NOFILL 2'h1
`define CMC_MESI_W 2
`define CMC_MESI_I 2'h0
`define CMC_MESI_S 2'h1
`define CMC_MESI_E 2'h2
`define CMC_MESI_M 2'h3
`define CMC_GP_CODE 16'h0000
`define CMC_CTRL_RST 32'h40000000
`endif

// ==== verilog/cmc_mode_ctrl.v ====
// cache mode control: control flags, fault check and access policy
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - cache disable flag is bit 30, privileged write
// - flag clear: caching allowed, attributes may restrict
// - flag set: restrict line allocation
// - flag set: snoops still answered
// - flag set imposes no strict ordering
// - normal: read hit served, miss allocates
// - write hit updates cached line both modes
// - only shared writes and misses reach memory
// - normal: write miss fills line
// - normal shared write hit: modified plus invalidate
// - normal: invalidation and snoops serviced
// - disable 0 with no write 1 faults
// - disable 1 no write 0 is no-fill, reset
// - no-fill: read miss never allocates
// - two state bits encode line coherency
module cmc_mode_ctrl (
    input wire clock_i,
    input wire rst_b_i,
    input wire ctrl_wr_i,
    input wire ctrl_priv_i,
    input wire [31:0] ctrl_wdata_i,
    output wire ctrl_done_o,
    output reg [31:0] ctrl_rdata_o,
    output reg protection_fault_o,
    output reg [15:0] fault_code_o,
    input wire range_types_on_i,
    input wire acc_valid_i,
    input wire acc_rd_i,
    input wire acc_wr_i,
    input wire acc_hit_i,
    input wire acc_uncached_i,
    input wire [1:0] acc_line_state_i,
    output reg pol_valid_o,
    output reg pol_allocate_o,
    output reg pol_update_line_o,
    output reg pol_mem_write_o,
    output reg pol_rd_inval_o,
    output reg [1:0] pol_new_state_o,
    output reg strict_order_o,
    input wire snoop_valid_i,
    input wire snoop_inval_i,
    input wire [1:0] snoop_line_state_i,
    output reg snoop_ack_o,
    output reg snoop_hitm_o,
    output reg [1:0] snoop_new_state_o,
    output reg [1:0] mode_o
);
`include "cmc_map.vh"
//////////////////////////////////////////////////////////////////////////////
    reg rst_sync1_q;
    reg rst_sync2_q;
    wire rst_b;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_b = rst_sync2_q;
//////////////////////////////////////////////////////////////////////////////
    reg [31:0] ctrl_q;
    reg [31:0] ctrl_d;
    reg fault_d;
    wire wr_cd;
    wire wr_nw;
    wire cd;
    wire nw;
    assign wr_cd = ctrl_wdata_i[`CMC_CD_BIT];
    assign wr_nw = ctrl_wdata_i[`CMC_NW_BIT];
    assign cd = ctrl_q[`CMC_CD_BIT];
    assign nw = ctrl_q[`CMC_NW_BIT];
    // write completes in the cycle it is taken
    assign ctrl_done_o = ctrl_wr_i;
    always @* begin
        ctrl_d = ctrl_q;
        fault_d = 1'b0;
        if (ctrl_wr_i) begin
            if (!ctrl_priv_i || (!wr_cd && wr_nw)) begin
                fault_d = 1'b1;
            end else begin
                ctrl_d = ctrl_wdata_i;
            end
        end
    end
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CMC_CTRL_RST;
            protection_fault_o <= 1'b0;
            fault_code_o <= `CMC_GP_CODE;
        end else begin
            ctrl_q <= ctrl_d;
            protection_fault_o <= fault_d;
            fault_code_o <= `CMC_GP_CODE;
        end
    end
    always @* begin
        ctrl_rdata_o = ctrl_q;
        mode_o = cd ? `CMC_MODE_NOFILL : `CMC_MODE_NORMAL;
    end
//////////////////////////////////////////////////////////////////////////////
    // mode sampled at issue so in-flight accesses keep the old one
    wire allocate;
    wire update_line;
    wire mem_write;
    wire rd_inval;
    wire [1:0] new_state;
    wire fill_ok;
    // an uncached miss must not claim a line state it never filled
    assign fill_ok = allocate && !acc_uncached_i;
    cmc_policy u_policy (
        .mode_i(mode_o),
        .rd_i(acc_rd_i),
        .wr_i(acc_wr_i),
        .hit_i(acc_hit_i),
        .line_state_i(acc_line_state_i),
        .allocate_o(allocate),
        .update_line_o(update_line),
        .mem_write_o(mem_write),
        .rd_inval_o(rd_inval),
        .new_state_o(new_state)
    );
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            pol_valid_o <= 1'b0;
            pol_allocate_o <= 1'b0;
            pol_update_line_o <= 1'b0;
            pol_mem_write_o <= 1'b0;
            pol_rd_inval_o <= 1'b0;
            pol_new_state_o <= `CMC_MESI_I;
            strict_order_o <= 1'b0;
        end else begin
            pol_valid_o <= acc_valid_i;
            // page and range attributes may still forbid a fill
            pol_allocate_o <= acc_valid_i && fill_ok;
            pol_update_line_o <= acc_valid_i && update_line;
            pol_mem_write_o <= acc_valid_i && mem_write;
            pol_rd_inval_o <= acc_valid_i && rd_inval;
            pol_new_state_o <= (acc_valid_i && !(acc_rd_i && !acc_hit_i && !fill_ok))
                ? new_state : acc_line_state_i;
            // disable flag alone never forces ordering
            strict_order_o <= !range_types_on_i || acc_uncached_i;
        end
    end
//////////////////////////////////////////////////////////////////////////////
    // snoops answered in every mode
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            snoop_ack_o <= 1'b0;
            snoop_hitm_o <= 1'b0;
            snoop_new_state_o <= `CMC_MESI_I;
        end else begin
            snoop_ack_o <= snoop_valid_i;
            snoop_hitm_o <= snoop_valid_i && (snoop_line_state_i == `CMC_MESI_M);
            if (snoop_inval_i || snoop_line_state_i == `CMC_MESI_I) begin
                snoop_new_state_o <= `CMC_MESI_I;
            end else begin
                snoop_new_state_o <= `CMC_MESI_S;
            end
        end
    end
endmodule // cmc_mode_ctrl

// ==== verilog/cmc_policy.v ====
// per-access cache policy decode from mode and line state
`timescale 1ns/10ps
module cmc_policy (
    input wire [1:0] mode_i,
    input wire rd_i,
    input wire wr_i,
    input wire hit_i,
    input wire [1:0] line_state_i,
    output reg allocate_o,
    output reg update_line_o,
    output reg mem_write_o,
    output reg rd_inval_o,
    output reg [1:0] new_state_o
);
`include "cmc_map.vh"
    // mode test shared by the read-miss, write-hit and write-miss paths
    function is_normal;
        input [1:0] m;
        begin
            is_normal = (m == `CMC_MODE_NORMAL);
        end
    endfunction
    always @* begin
        allocate_o = 1'b0;
        update_line_o = 1'b0;
        mem_write_o = 1'b0;
        rd_inval_o = 1'b0;
        new_state_o = line_state_i;
        if (rd_i && !hit_i) begin
            allocate_o = is_normal(mode_i);
            if (is_normal(mode_i)) begin
                new_state_o = `CMC_MESI_E;
            end
        end
        if (wr_i && hit_i) begin
            update_line_o = 1'b1;
            mem_write_o = (line_state_i == `CMC_MESI_S);
            if (line_state_i == `CMC_MESI_E) begin
                new_state_o = `CMC_MESI_M;
            end
            if (line_state_i == `CMC_MESI_S && is_normal(mode_i)) begin
                new_state_o = `CMC_MESI_M;
                rd_inval_o = 1'b1;
            end
        end
        if (wr_i && !hit_i) begin
            mem_write_o = 1'b1;
            allocate_o = is_normal(mode_i);
        end
    end
endmodule // cmc_policy
